// >>> hdl/irq_group_source_mapping.sv
/*
  Interrupt source mapper for three aggregation groups (ten, eleven,
  twelve) with source, enable-set, enable-clear and result registers,
  pin detection registers and an AXI4-Lite slave.
  Assumes all inputs synchronous to aclk and an AXI4-Lite master
  with at most one write and one read outstanding.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
`include "irq_group_cfg.svh"

// Operation
// - Group ten bits 7..0 latch events of pins 040..047 in order.
// - Group ten bits 15..8 latch wake events of pins 050..057.
// - Group ten bits 23..16 latch pins 060..067; bits 31..24 reserved.
// - Group eleven bits 7..0 latch wake events of pins 000..007.
// - Group eleven bits 15..8 latch wake events of pins 010..017.
// - Group eleven bits 23..16 latch wake events of pins 020..027.
// - Group eleven bits 30..24 latch wake events of pins 030..036.
// - Pin event is high, low, rising or falling per detection field.
// - Group twelve bits 0..3 set by bus controller requests 0..3.
// - Group twelve bit 4 set by bus 0 port 0 data activity.
// - Group twelve bit 5 set by bus 0 port 1 data activity.
// - Group twelve bit 6 set by bus 2 port 0 data activity.
// - Group twelve bit 7 set by bus 1 port 0 data activity.
// - Group twelve bit 8 set by bus 3 port 0 activity; rest reserved.
module irq_group_source_mapping (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [23:0] pin_ten_level,
  input  wire logic [30:0] pin_eleven_level,
  input  wire logic [3:0]  bus_irq_req,
  input  wire logic        bus0_port0_data_line,
  input  wire logic        bus0_port1_data_line,
  input  wire logic        bus2_port0_data_line,
  input  wire logic        bus1_port0_data_line,
  input  wire logic        bus3_port0_data_line,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  output logic             wake,
  output logic [2:0]       group_result
);
  import irq_group_pkg::*;

  irq_group_pkg::state_s st;
  irq_group_pkg::state_s nx;
  logic [23:0]           ev_ten;
  logic [30:0]           ev_eleven;
  logic [4:0]            data_now;
  logic [4:0]            data_act;

  // Event from one pin under its detection type
  function automatic logic pin_event(input det_e d, input logic cur,
                                     input logic prv);
    case (d)
      DET_HIGH: pin_event = cur;
      DET_LOW:  pin_event = !cur;
      DET_RISE: pin_event = cur && !prv;
      DET_FALL: pin_event = !cur && prv;
      default:  pin_event = 1'b0;
    endcase
  endfunction

  // Address lies inside the register window
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:`MAP_TOP_LSB] == '0);
  endfunction

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Register read mux
  function automatic logic [31:0] read_word(input state_s s,
                                            input logic [3:0] idx);
    logic [1:0] g;
    g = idx[3:2];
    read_word = 32'h0000_0000;
    if (g == `GROUP_DET)
    begin
      case (idx[1:0])
        2'h0:    read_word = s.det_ten[15:0];
        2'h1:    read_word = {16'h0000, s.det_ten[23:16]};
        2'h2:    read_word = s.det_eleven[15:0];
        default: read_word = {2'h0, s.det_eleven[30:16]};
      endcase
    end
    else
    begin
      case (idx[1:0])
        `KIND_SRC:    read_word = s.src[g];
        `KIND_RESULT: read_word = s.src[g] & s.en[g];
        default:      read_word = s.en[g];
      endcase
    end
  endfunction

  // Pin event decode, groups ten and eleven
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++)
    begin : g_ten
      assign ev_ten[gi] = pin_event(det_e'(st.det_ten[gi]),
                                    pin_ten_level[gi], st.prev_ten[gi]);
    end
    for (gi = 0; gi < 31; gi++)
    begin : g_eleven
      assign ev_eleven[gi] = pin_event(det_e'(st.det_eleven[gi]),
                                       pin_eleven_level[gi],
                                       st.prev_eleven[gi]);
    end
  endgenerate

  // Data line activity: any change since last cycle
  assign data_now = {bus3_port0_data_line, bus1_port0_data_line,
                     bus2_port0_data_line, bus0_port1_data_line,
                     bus0_port0_data_line};
  assign data_act = data_now ^ st.prev_data;

  // Next-state logic
  always_comb
  begin
    logic [2:0][31:0] set_v;
    logic [2:0][31:0] valid_v;
    logic [2:0][31:0] wake_v;
    logic [2:0][31:0] clr_v;
    logic [2:0][31:0] ens_v;
    logic [2:0][31:0] enc_v;
    logic [2:0][31:0] res_v;
    logic [31:0]      bm;
    logic [31:0]      wd;
    logic [3:0]       idx;
    set_v   = '0;
    valid_v = '0;
    wake_v  = '0;
    clr_v   = '0;
    ens_v   = '0;
    enc_v   = '0;
    res_v   = '0;
    bm      = byte_mask(st.wstrb);
    wd      = st.wdata & bm;
    idx     = st.awaddr[5:2];
    nx      = st;
    set_v[0][7:0]   = ev_ten[7:0];
    set_v[0][15:8]  = ev_ten[15:8];
    set_v[0][23:16] = ev_ten[23:16];
    set_v[1][7:0]   = ev_eleven[7:0];
    set_v[1][15:8]  = ev_eleven[15:8];
    set_v[1][23:16] = ev_eleven[23:16];
    set_v[1][30:24] = ev_eleven[30:24];
    set_v[2] = {28'h0000000, bus_irq_req} << `TWELVE_BUS_IRQ_LSB;
    set_v[2] = set_v[2] | ({27'h0000000, data_act} << `TWELVE_DATA_LSB);
    valid_v[0] = `TEN_VALID;
    valid_v[1] = `ELEVEN_VALID;
    valid_v[2] = `TWELVE_VALID;
    wake_v[0]  = `TEN_WAKE;
    wake_v[1]  = `ELEVEN_WAKE;
    wake_v[2]  = `TWELVE_WAKE;
    nx.prev_ten    = pin_ten_level;
    nx.prev_eleven = pin_eleven_level;
    nx.prev_data   = data_now;

    // Write address and data capture, either order
    if (awvalid && st.awready)
    begin
      nx.aw_got  = 1'b1;
      nx.awaddr  = awaddr;
      nx.awready = 1'b0;
    end
    if (wvalid && st.wready)
    begin
      nx.w_got  = 1'b1;
      nx.wdata  = wdata;
      nx.wstrb  = wstrb;
      nx.wready = 1'b0;
    end

    // Write execution and response
    case (st.wst)
      W_IDLE:
      begin
        if (st.aw_got && st.w_got)
        begin
          nx.aw_got = 1'b0;
          nx.w_got  = 1'b0;
          nx.bvalid = 1'b1;
          nx.bresp  = `RESP_OKAY;
          nx.wst    = W_RESP;
          if (!addr_hit(st.awaddr))
            nx.bresp = `RESP_SLVERR;
          else if (idx[3:2] == `GROUP_DET)
          begin
            case (idx[1:0])
              2'h0: nx.det_ten[15:0] = (st.det_ten[15:0] & ~bm) | wd;
              2'h1: nx.det_ten[23:16] =
                      (st.det_ten[23:16] & ~bm[15:0]) | wd[15:0];
              2'h2: nx.det_eleven[15:0] =
                      (st.det_eleven[15:0] & ~bm) | wd;
              default: nx.det_eleven[30:16] =
                      (st.det_eleven[30:16] & ~bm[29:0]) | wd[29:0];
            endcase
          end
          else
          begin
            case (idx[1:0])
              `KIND_SRC:    clr_v[idx[3:2]] = wd;
              `KIND_EN_SET: ens_v[idx[3:2]] = wd;
              `KIND_EN_CLR: enc_v[idx[3:2]] = wd;
              default:      clr_v = '0;
            endcase
          end
        end
      end
      W_RESP:
      begin
        if (bready)
        begin
          nx.bvalid  = 1'b0;
          nx.awready = 1'b1;
          nx.wready  = 1'b1;
          nx.wst     = W_IDLE;
        end
      end
      default: nx.wst = W_IDLE;
    endcase

    // Sticky sources, set wins over clear; enables set and clear
    for (int g = 0; g < 3; g++)
    begin
      nx.src[g] = ((st.src[g] & ~clr_v[g]) | set_v[g]) & valid_v[g];
      nx.en[g]  = ((st.en[g] & ~enc_v[g]) | ens_v[g]) & valid_v[g];
      res_v[g]  = nx.src[g] & nx.en[g];
      nx.group_result[g] = |res_v[g];
    end
    nx.irq  = |nx.group_result;
    nx.wake = |((res_v[0] & wake_v[0]) | (res_v[1] & wake_v[1]) |
                (res_v[2] & wake_v[2]));

    // Read channel
    case (st.rst)
      R_IDLE:
      begin
        if (arvalid && st.arready)
        begin
          nx.arready = 1'b0;
          nx.rvalid  = 1'b1;
          nx.rst     = R_DATA;
          if (addr_hit(araddr))
          begin
            nx.rdata = read_word(st, araddr[5:2]);
            nx.rresp = `RESP_OKAY;
          end
          else
          begin
            nx.rdata = 32'h0000_0000;
            nx.rresp = `RESP_SLVERR;
          end
        end
      end
      R_DATA:
      begin
        if (rready)
        begin
          nx.rvalid  = 1'b0;
          nx.arready = 1'b1;
          nx.rst     = R_IDLE;
        end
      end
      default: nx.rst = R_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st            <= '0;
      st.src        <= {3{`SRC_RESET}};
      st.en         <= {3{`EN_RESET}};
      st.det_ten    <= {24{`DET_RESET}};
      st.det_eleven <= {31{`DET_RESET}};
      st.awready    <= 1'b1;
      st.wready     <= 1'b1;
      st.arready    <= 1'b1;
    end
    else
      st <= nx;
  end

  // Outputs straight from the state register
  assign awready      = st.awready;
  assign wready       = st.wready;
  assign bresp        = st.bresp;
  assign bvalid       = st.bvalid;
  assign arready      = st.arready;
  assign rdata        = st.rdata;
  assign rresp        = st.rresp;
  assign rvalid       = st.rvalid;
  assign irq          = st.irq;
  assign wake         = st.wake;
  assign group_result = st.group_result;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_TEN_LOW: assert property (
    ev_ten[7:0] != 8'h00 |=>
      (st.src[0][7:0] & $past(ev_ten[7:0])) == $past(ev_ten[7:0]))
    else $error("group ten low pin event lost");
  AST_TEN_MID: assert property (
    ev_ten[15:8] != 8'h00 |=>
      (st.src[0][15:8] & $past(ev_ten[15:8])) == $past(ev_ten[15:8]))
    else $error("group ten mid pin event lost");
  AST_TEN_HIGH: assert property (
    ev_ten[16] |=> st.src[0][16] && st.src[0][31:24] == 8'h00)
    else $error("group ten high pin or reserved bits wrong");
  AST_ELEVEN_LOW: assert property (
    ev_eleven[0] && ev_eleven[7] |=> st.src[1][0] && st.src[1][7])
    else $error("group eleven low pin event lost");
  AST_ELEVEN_MID: assert property (
    ev_eleven[8] |=> st.src[1][8])
    else $error("group eleven mid pin event lost");
  AST_ELEVEN_UPPER: assert property (
    ev_eleven[23] |=> st.src[1][23])
    else $error("group eleven upper pin event lost");
  AST_ELEVEN_TOP: assert property (
    ev_eleven[30] |=> st.src[1][30] ##1 !st.src[1][31])
    else $error("group eleven top pin event lost");
  AST_DET_FALL: assert property (
    det_e'(st.det_eleven[0]) == DET_FALL && st.prev_eleven[0] &&
      !pin_eleven_level[0] |=> st.src[1][0])
    else $error("falling edge not detected");
  AST_DET_RISE_ONLY: assert property (
    det_e'(st.det_ten[0]) == DET_RISE && pin_ten_level[0] &&
      st.prev_ten[0] |-> !ev_ten[0])
    else $error("rising detect fired on steady high");
  AST_BUS_REQ: assert property (
    bus_irq_req != 4'h0 |=>
      (st.src[2][3:0] & $past(bus_irq_req)) == $past(bus_irq_req))
    else $error("bus controller request lost");
  AST_B0P0_ACT: assert property (
    bus0_port0_data_line != st.prev_data[0] |=> st.src[2][4])
    else $error("bus 0 port 0 activity lost");
  AST_B0P1_ACT: assert property (
    bus0_port1_data_line != st.prev_data[1] |=> st.src[2][5])
    else $error("bus 0 port 1 activity lost");
  AST_B2P0_ACT: assert property (
    bus2_port0_data_line != st.prev_data[2] |=> st.src[2][6])
    else $error("bus 2 port 0 activity lost");
  AST_B1P0_ACT: assert property (
    bus1_port0_data_line != st.prev_data[3] |=> st.src[2][7])
    else $error("bus 1 port 0 activity lost");
  AST_B3P0_ACT: assert property (
    bus3_port0_data_line != st.prev_data[4] |=>
      st.src[2][8] && st.src[2][31:9] == 23'h000000)
    else $error("bus 3 port 0 activity lost");
  AST_RESERVED: assert property (
    ((st.src[0] | st.en[0]) & ~`TEN_VALID) == 32'h0 &&
      ((st.src[2] | st.en[2]) & ~`TWELVE_VALID) == 32'h0 && !st.en[1][31])
    else $error("reserved bit leaked into result");
  AST_IRQ_LEVEL: assert property (
    st.irq == |((st.src[0] & st.en[0]) | (st.src[1] & st.en[1]) |
                (st.src[2] & st.en[2])))
    else $error("interrupt level disagrees with result");
endmodule

// >>> hdl/irq_group_cfg.svh
/*
  Constants of the three-group interrupt source mapper: offsets,
  field masks, field positions and reset values.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef IRQ_GROUP_CFG_SVH
`define IRQ_GROUP_CFG_SVH

// Byte offsets of each register
`define OFF_TEN_SRC        32'h0000_0000
`define OFF_TEN_EN_SET     32'h0000_0004
`define OFF_TEN_EN_CLR     32'h0000_0008
`define OFF_TEN_RESULT     32'h0000_000c
`define OFF_ELEVEN_SRC     32'h0000_0010
`define OFF_ELEVEN_EN_SET  32'h0000_0014
`define OFF_ELEVEN_EN_CLR  32'h0000_0018
`define OFF_ELEVEN_RESULT  32'h0000_001c
`define OFF_TWELVE_SRC     32'h0000_0020
`define OFF_TWELVE_EN_SET  32'h0000_0024
`define OFF_TWELVE_EN_CLR  32'h0000_0028
`define OFF_TWELVE_RESULT  32'h0000_002c
`define OFF_DET_TEN_LO     32'h0000_0030
`define OFF_DET_TEN_HI     32'h0000_0034
`define OFF_DET_ELEVEN_LO  32'h0000_0038
`define OFF_DET_ELEVEN_HI  32'h0000_003c

// Address decode fields: word index is addr[5:2]
`define MAP_TOP_LSB        6
`define GROUP_DET          2'h3
`define KIND_SRC           2'h0
`define KIND_EN_SET        2'h1
`define KIND_EN_CLR        2'h2
`define KIND_RESULT        2'h3

// Implemented and wake-capable bits per group
`define TEN_VALID          32'h00ff_ffff
`define ELEVEN_VALID       32'h7fff_ffff
`define TWELVE_VALID       32'h0000_01ff
`define TEN_WAKE           32'h00ff_ffff
`define ELEVEN_WAKE        32'h7fff_ffff
`define TWELVE_WAKE        32'h0000_01f0

// Field positions in group twelve
`define TWELVE_BUS_IRQ_LSB 0
`define TWELVE_DATA_LSB    4

// Reset values
`define SRC_RESET          32'h0000_0000
`define EN_RESET           32'h0000_0000
`define DET_RESET          2'h0

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> hdl/irq_group_pkg.sv
/*
  Types of the three-group interrupt source mapper.
  Assumes nothing of its surroundings.
*/
package irq_group_pkg;

  // Pin detection type codes
  typedef enum logic [1:0] {
    DET_HIGH = 2'b00,
    DET_LOW  = 2'b01,
    DET_RISE = 2'b10,
    DET_FALL = 2'b11
  } det_e;

  typedef enum logic [0:0] {
    W_IDLE = 1'b0,
    W_RESP = 1'b1
  } wr_e;

  typedef enum logic [0:0] {
    R_IDLE = 1'b0,
    R_DATA = 1'b1
  } rd_e;

  typedef struct packed {
    wr_e               wst;
    rd_e               rst;
    logic              aw_got;
    logic              w_got;
    logic [31:0]       awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [2:0][31:0]  src;
    logic [2:0][31:0]  en;
    logic [23:0][1:0]  det_ten;
    logic [30:0][1:0]  det_eleven;
    logic [23:0]       prev_ten;
    logic [30:0]       prev_eleven;
    logic [4:0]        prev_data;
    logic              irq;
    logic              wake;
    logic [2:0]        group_result;
  } state_s;

endpackage

// >>> tb/irq_event_source.sv
/*
  Event source model: pin levels, bus controller requests and the
  serial data lines seen by the mapper.
  Assumes the bench sets the wanted levels just after an aclk edge.
*/
module irq_event_source (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [23:0] ten_want,
  input  wire logic [30:0] eleven_want,
  input  wire logic [3:0]  req_want,
  input  wire logic [4:0]  line_want,
  output logic [23:0]      ten_pins,
  output logic [30:0]      eleven_pins,
  output logic [3:0]       req,
  output logic [4:0]       lines
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ten_pins    <= '0;
      eleven_pins <= '0;
      req         <= '0;
      lines       <= '0;
    end
    else
    begin
      ten_pins    <= ten_want;
      eleven_pins <= eleven_want;
      req         <= req_want;
      lines       <= line_want;
    end
  end
endmodule

// >>> tb/irq_group_source_mapping_tb.sv
/*
  Self-checking bench of the three-group interrupt source mapper.
  Assumes the design package and constant header are compiled first.
*/
`include "irq_group_cfg.svh"
module irq_group_source_mapping_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [23:0] ten_want = '0;
  logic [30:0] eleven_want = '0;
  logic [3:0]  req_want = '0;
  logic [4:0]  line_want = '0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  group_result;
  logic [23:0] ten_pins;
  logic [30:0] eleven_pins;
  logic [3:0]  req;
  logic [4:0]  lines;
  int          fails = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'h49a7;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [31:0] valid_m [3] = '{`TEN_VALID, `ELEVEN_VALID, `TWELVE_VALID};

  irq_event_source i_irq_event_source (
    .aclk(aclk), .aresetn(aresetn), .ten_want(ten_want),
    .eleven_want(eleven_want), .req_want(req_want), .line_want(line_want),
    .ten_pins(ten_pins), .eleven_pins(eleven_pins), .req(req),
    .lines(lines));

  irq_group_source_mapping i_irq_group_source_mapping (
    .aclk(aclk), .aresetn(aresetn), .pin_ten_level(ten_pins),
    .pin_eleven_level(eleven_pins), .bus_irq_req(req),
    .bus0_port0_data_line(lines[0]), .bus0_port1_data_line(lines[1]),
    .bus2_port0_data_line(lines[2]), .bus1_port0_data_line(lines[3]),
    .bus3_port0_data_line(lines[4]), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
    .wake(wake), .group_result(group_result));

  // Clock and watchdog
  initial
    forever #12.5 aclk = ~aclk;
  initial
  begin
    #500us;
    fails++;
    end_sim();
  end

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf,
                    input logic [1:0] r = `RESP_OKAY);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw || (awvalid && awready);
      w = w || (wvalid && wready);
      awvalid <= !aw;
      wvalid <= !w;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // Read: note the expected answer, then run the handshakes
  task automatic rd(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY);
    exp_r.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic chk_out(input logic wk, input logic [2:0] g);
    @(negedge aclk);
    check({29'h0, irq, wake, group_result}, {29'h0, |g, wk, g});
  endtask

  task automatic pin0(input logic v);
    @(posedge aclk);
    ten_want <= {23'h0, v};
    repeat (3) @(posedge aclk);
  endtask

  // Oldest note against each answer
  always @(posedge aclk)
  begin
    if (rvalid && rready)
      check({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready)
      check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  // Main sequence
  initial
  begin
    int          i;
    logic [31:0] r1, r2;
    logic        a;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 16; i++)
      rd(i * 4, 0);
    for (i = 0; i < 3; i++)
    begin
      wr(i * 16 + 4, '1);
      rd(i * 16 + 4, valid_m[i]);
    end
    // Random pin patterns through groups ten and eleven
    repeat (4)
    begin
      // A few fixed bits so every pin range sees an event
      r1 = (next_rand() | 32'h0001_0101) & `TEN_VALID;
      r2 = (next_rand() | 32'h4080_0181) & `ELEVEN_VALID;
      @(posedge aclk);
      ten_want <= r1[23:0];
      eleven_want <= r2[30:0];
      @(posedge aclk);
      ten_want <= '0;
      eleven_want <= '0;
      repeat (3) @(posedge aclk);
      wr(`OFF_TEN_RESULT, 0);
      rd(`OFF_TEN_SRC, r1);
      rd(`OFF_TEN_RESULT, r1);
      rd(`OFF_ELEVEN_SRC, r2);
      chk_out((|r1) | (|r2), {1'b0, |r2, |r1});
      wr(`OFF_TEN_SRC, '1);
      wr(`OFF_ELEVEN_SRC, '1);
      rd(`OFF_ELEVEN_SRC, 0);
    end
    // Each detection code on the first pin of group ten
    for (i = 0; i < 4; i++)
    begin
      wr(`OFF_DET_TEN_LO, i);
      pin0(1'b0);
      wr(`OFF_TEN_SRC, '1);
      a = (i == 1);
      rd(`OFF_TEN_SRC, a);
      pin0(1'b1);
      a = a | (i == 0) | (i == 2);
      rd(`OFF_TEN_SRC, a);
      wr(`OFF_TEN_SRC, '1);
      a = (i == 0);
      rd(`OFF_TEN_SRC, a);
      pin0(1'b0);
      a = a | (i == 3) | (i == 1);
      rd(`OFF_TEN_SRC, a);
    end
    wr(`OFF_DET_TEN_LO, 0);
    wr(`OFF_TEN_SRC, '1);
    // Falling detect on the first pin of group eleven
    wr(`OFF_DET_ELEVEN_LO, 3);
    rd(`OFF_DET_ELEVEN_LO, 3);
    @(posedge aclk);
    eleven_want <= 31'h1;
    repeat (3) @(posedge aclk);
    rd(`OFF_ELEVEN_SRC, 0);
    eleven_want <= '0;
    repeat (3) @(posedge aclk);
    rd(`OFF_ELEVEN_SRC, 1);
    wr(`OFF_DET_ELEVEN_LO, 0);
    wr(`OFF_ELEVEN_SRC, '1);
    rd(`OFF_ELEVEN_SRC, 0);
    // Controller requests raise the interrupt but not wake
    r1 = next_rand() | 32'h1;
    @(posedge aclk);
    req_want <= r1[3:0];
    @(posedge aclk);
    req_want <= '0;
    repeat (3) @(posedge aclk);
    rd(`OFF_TWELVE_SRC, r1[3:0]);
    chk_out(1'b0, 3'b100);
    wr(`OFF_TWELVE_SRC, '1);
    // Each data line toggle sets its own wake bit
    for (i = 0; i < 5; i++)
    begin
      @(posedge aclk);
      line_want[i] <= !line_want[i];
      repeat (3) @(posedge aclk);
      rd(`OFF_TWELVE_SRC, 32'h10 << i);
      chk_out(1'b1, 3'b100);
      wr(`OFF_TWELVE_SRC, '1);
    end
    // Masked event stays pending; a one-byte enable unmasks it
    wr(`OFF_TWELVE_EN_CLR, '1);
    rd(`OFF_TWELVE_EN_SET, 0);
    @(posedge aclk);
    line_want[0] <= !line_want[0];
    repeat (3) @(posedge aclk);
    chk_out(1'b0, 3'b000);
    rd(`OFF_TWELVE_RESULT, 0);
    wr(`OFF_TWELVE_EN_SET, '1, 4'h1);
    rd(`OFF_TWELVE_EN_CLR, 32'hff);
    rd(`OFF_TWELVE_RESULT, 32'h10);
    chk_out(1'b1, 3'b100);
    // Unmapped addresses answer with an error
    rd(32'h40, 0, `RESP_SLVERR);
    wr(32'h80, '1, 4'hf, `RESP_SLVERR);
    // Second reset clears enables and outputs
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_TWELVE_EN_SET, 0);
    chk_out(1'b0, 3'b000);
    end_sim();
  end
endmodule
